// ---- verilog/sci_pkg.sv ----
// Overview of operation
// - All inputs but the asynchronous reset sampled only at rising clock edge.
// - Read: cs, cas low; ras, we high.
// - Write: cs, cas, we low; ras high.
// - Mode load: all four strobes low, address stored.
// - Decode uses present and prior clock enable.
// - Bank selects pick bank; access needs open bank.
// - Burst stop honoured only during full-page burst.
// - Enable low: idle powers down, burst suspends.
// - New row needs precharge; accesses every clock.
// - Mode sets burst type and length.
// - Data after a write burst is ignored.
// - Read interrupts read; old data drains first.
// - Precharge code; address ten selects all banks.
// - No-operation never ends a running burst.
// - Address ten on access requests auto precharge.
// - Refresh code; enable low means self refresh.
package sci_pkg;
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 12;
  localparam int COL_W = 10;
  localparam int DATA_W = 4;
  localparam int MEM_COL_W = 4;
  localparam int MEM_ROW_W = 1;
  localparam int IDX_W = BANK_W + MEM_ROW_W + MEM_COL_W;
  localparam int FIFO_DEPTH = 8;
  localparam int AUTO_PRE_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_MODE_LOAD = 3'h0;
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_BURST_STOP = 3'h6;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
  localparam logic [3:0] REFRESH_RESET = 4'h0;
  localparam logic [3:0] REFRESH_MAX = 4'hF;
  localparam logic CKE_PREV_RESET = 1'b0;

  typedef enum logic [1:0] {
    SCI_RUN = 2'b00,
    SCI_SUSPEND = 2'b01,
    SCI_PWRDN = 2'b11,
    SCI_SELFREF = 2'b10
  } sci_power_t;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] data;
  } sci_wr_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } sci_rd_t;
endpackage

// ---- verilog/sci_sdram_device.sv ----
`timescale 1ns/1ps
module sci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = count_reg != (PTR_W+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign out_data = store_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + PTR_W'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (PTR_W+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (PTR_W+1)'(1);
      end
    end
  end
endmodule // sci_fifo

module sci_sdram_device
  import sci_pkg::*;
#(
  parameter int WBUF_DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic dqm,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic wbuf_ready,
  output logic [BANKS-1:0] bank_open,
  output sci_power_t power_state,
  output logic [ADDR_W-1:0] mode_value,
  output logic mode_loaded,
  output logic [3:0] refresh_count,
  output logic prior_cycle_clock_enable
);
  logic cke_prev_reg;
  sci_power_t power_reg;
  logic [ADDR_W-1:0] mode_reg;
  logic mode_loaded_reg;
  logic [3:0] refresh_count_reg;
  logic open_reg [BANKS];
  logic [MEM_ROW_W-1:0] row_reg [BANKS];
  logic [BANKS-1:0] open_vec;
  logic burst_active_reg;
  logic burst_write_reg;
  logic [BANK_W-1:0] burst_bank_reg;
  logic [COL_W-1:0] burst_start_reg;
  logic [COL_W-1:0] burst_cnt_reg;
  logic burst_ap_reg;
  sci_rd_t pipe_reg [2];
  sci_rd_t pipe_out;
  logic dqm_d1_reg;
  logic [DATA_W-1:0] dq_out_reg;
  logic dq_oe_reg;
  logic wbuf_ready_reg;
  logic [DATA_W-1:0] mem_reg [2**IDX_W];

  logic run;
  logic sel;
  logic [2:0] cmd;
  logic [BANK_W-1:0] bank;
  logic [2:0] bl;
  logic [2:0] cl;
  logic ilv;
  logic full_page;
  logic all_idle;
  logic [COL_W-1:0] msk;
  logic rw_cmd;
  logic new_go;
  logic bst_go;
  logic mrs_go;
  logic ref_go;
  logic beat_now;
  logic beat_write;
  logic [BANK_W-1:0] beat_bank;
  logic [COL_W-1:0] beat_cnt;
  logic [COL_W-1:0] beat_start;
  logic [COL_W-1:0] beat_col;
  logic beat_ap;
  logic beat_last;
  logic rd_beat;
  logic ap_close;
  sci_wr_t wr_word;
  sci_wr_t drain_word;
  logic wfifo_in_valid;
  logic wfifo_in_ready;
  logic wfifo_out_valid;
  logic wfifo_out_ready;

  // Commands count only when enable was high one edge earlier; a low enable freezes the core.
  assign run = cke_prev_reg;
  assign sel = run && !cs_n;
  assign cmd = {ras_n, cas_n, we_n};
  assign bank = {bank_select_high, bank_select_low};
  assign bl = mode_reg[MR_BL_LSB +: 3];
  assign cl = mode_reg[MR_CL_LSB +: 3];
  assign full_page = bl == BL_FULL;
  assign ilv = mode_reg[MR_BT_BIT] && !full_page;
  assign all_idle = (open_vec == '0) && !burst_active_reg;

  always_comb begin
    case (bl)
      BL_2: msk = COL_W'(1);
      BL_4: msk = COL_W'(3);
      BL_8: msk = COL_W'(7);
      BL_FULL: msk = '1;
      default: msk = '0;
    endcase
  end

  // An access is taken only into an open bank and never breaks an auto-precharge burst.
  assign rw_cmd = sel && (cmd == CMD_READ || cmd == CMD_WRITE);
  assign new_go = rw_cmd && open_vec[bank] && !(burst_active_reg && burst_ap_reg);
  assign bst_go = sel && cmd == CMD_BURST_STOP && full_page && burst_active_reg;
  assign mrs_go = sel && cmd == CMD_MODE_LOAD && all_idle;
  assign ref_go = sel && cmd == CMD_REFRESH && cke && all_idle;

  // A no-operation leaves the burst running; only stop, a new access or its end close it.
  assign beat_now = new_go || (run && burst_active_reg && !bst_go);
  assign beat_write = new_go ? (cmd == CMD_WRITE) : burst_write_reg;
  assign beat_bank = new_go ? bank : burst_bank_reg;
  assign beat_cnt = new_go ? '0 : burst_cnt_reg;
  assign beat_start = new_go ? addr[COL_W-1:0] : burst_start_reg;
  assign beat_ap = new_go ? addr[AUTO_PRE_BIT] : burst_ap_reg;
  assign beat_last = beat_cnt == msk;
  assign beat_col = (beat_start & ~msk) |
    ((ilv ? (beat_start ^ beat_cnt) : (beat_start + beat_cnt)) & msk);
  assign rd_beat = beat_now && !beat_write;
  assign ap_close = beat_now && beat_last && beat_ap;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cke_prev_reg <= CKE_PREV_RESET;
    end else begin
      cke_prev_reg <= cke;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      power_reg <= SCI_RUN;
    end else begin
      case (power_reg)
        SCI_RUN: begin
          if (cke_prev_reg && !cke) begin
            if (burst_active_reg || new_go) begin
              power_reg <= SCI_SUSPEND;
            end else if (sel && cmd == CMD_REFRESH && all_idle) begin
              power_reg <= SCI_SELFREF;
            end else begin
              power_reg <= SCI_PWRDN;
            end
          end
        end
        default: begin
          if (!cke_prev_reg && cke) begin
            power_reg <= SCI_RUN;
          end
        end
      endcase
    end
  end

  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    assign open_vec[b] = open_reg[b];
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        open_reg[b] <= 1'b0;
        row_reg[b] <= '0;
      end else if (sel && cmd == CMD_ACTIVATE && bank == BANK_W'(b) && !open_reg[b]) begin
        open_reg[b] <= 1'b1;
        row_reg[b] <= addr[MEM_ROW_W-1:0];
      end else if ((sel && cmd == CMD_PRECHARGE && (addr[AUTO_PRE_BIT] || bank == BANK_W'(b)))
                   || (ap_close && beat_bank == BANK_W'(b))) begin
        open_reg[b] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      burst_active_reg <= 1'b0;
      burst_write_reg <= 1'b0;
      burst_bank_reg <= '0;
      burst_start_reg <= '0;
      burst_cnt_reg <= '0;
      burst_ap_reg <= 1'b0;
    end else if (new_go) begin
      // A new access restarts a full-length burst at its own column.
      burst_active_reg <= msk != '0;
      burst_write_reg <= cmd == CMD_WRITE;
      burst_bank_reg <= bank;
      burst_start_reg <= addr[COL_W-1:0];
      burst_cnt_reg <= COL_W'(1);
      burst_ap_reg <= addr[AUTO_PRE_BIT];
    end else if (bst_go) begin
      burst_active_reg <= 1'b0;
    end else if (run && burst_active_reg) begin
      burst_cnt_reg <= burst_cnt_reg + COL_W'(1);
      if (beat_last) begin
        burst_active_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_reg <= MODE_RESET;
      mode_loaded_reg <= 1'b0;
      refresh_count_reg <= REFRESH_RESET;
    end else begin
      if (mrs_go) begin
        mode_reg <= addr;
        mode_loaded_reg <= 1'b1;
      end
      if (ref_go && refresh_count_reg != REFRESH_MAX) begin
        refresh_count_reg <= refresh_count_reg + 4'h1;
      end
    end
  end

  // Write beats are taken only inside a burst, so trailing bus data never reaches the array.
  assign wfifo_in_valid = beat_now && beat_write && !dqm;
  assign wr_word = '{idx: {beat_bank, row_reg[beat_bank], beat_col[MEM_COL_W-1:0]}, data: dq_in};
  // The array has one port, so draining yields to read beats and stops while the clock is gated.
  assign wfifo_out_ready = power_reg == SCI_RUN && !rd_beat;

  sci_fifo #(
    .WIDTH($bits(sci_wr_t)),
    .DEPTH(WBUF_DEPTH)
  ) u_wbuf (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(wfifo_in_valid),
    .in_ready(wfifo_in_ready),
    .in_data(wr_word),
    .out_valid(wfifo_out_valid),
    .out_ready(wfifo_out_ready),
    .out_data(drain_word)
  );

  always_ff @(posedge sys_clk) begin
    if (wfifo_out_valid && wfifo_out_ready) begin
      mem_reg[drain_word.idx] <= drain_word.data;
    end
  end

  assign pipe_out = (cl == CL_3) ? pipe_reg[1] : pipe_reg[0];

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pipe_reg[0] <= '0;
      pipe_reg[1] <= '0;
      dqm_d1_reg <= 1'b0;
      dq_out_reg <= '0;
      dq_oe_reg <= 1'b0;
    end else if (run) begin
      dqm_d1_reg <= dqm;
      if (new_go && cmd == CMD_WRITE) begin
        // The write owns the bus at once; pending read data is dropped.
        pipe_reg[0] <= '0;
        pipe_reg[1] <= '0;
        dq_oe_reg <= 1'b0;
      end else begin
        pipe_reg[0] <= '{valid: rd_beat, data: rd_beat ?
          mem_reg[{beat_bank, row_reg[beat_bank], beat_col[MEM_COL_W-1:0]}] : '0};
        pipe_reg[1] <= pipe_reg[0];
        dq_oe_reg <= pipe_out.valid && !dqm_d1_reg;
        dq_out_reg <= pipe_out.data;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wbuf_ready_reg <= 1'b0;
    end else begin
      wbuf_ready_reg <= wfifo_in_ready;
    end
  end

  assign dq_out = dq_out_reg;
  assign dq_oe = dq_oe_reg;
  assign wbuf_ready = wbuf_ready_reg;
  assign bank_open = open_vec;
  assign power_state = power_reg;
  assign mode_value = mode_reg;
  assign mode_loaded = mode_loaded_reg;
  assign refresh_count = refresh_count_reg;
  assign prior_cycle_clock_enable = cke_prev_reg;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_read_enters_pipe: assert property (new_go && cmd == CMD_READ |=> pipe_reg[0].valid)
    else $error("read command did not load the read pipe");
  a_write_buffered: assert property (new_go && cmd == CMD_WRITE && !dqm && wfifo_in_ready
    |=> wfifo_out_valid)
    else $error("write beat was not buffered");
  a_mode_stored: assert property (mrs_go |=> mode_reg == $past(addr))
    else $error("mode load did not store the address");
  a_cke_freeze: assert property (!cke_prev_reg |=> $stable(burst_cnt_reg) &&
    $stable(burst_active_reg))
    else $error("burst advanced while clock enable was low");
  a_closed_bank_ignored: assert property (rw_cmd && !open_vec[bank] && !burst_active_reg
    |=> !burst_active_reg)
    else $error("access to a closed bank started a burst");
  a_stop_fullpage: assert property (sel && cmd == CMD_BURST_STOP && !full_page &&
    burst_active_reg && !beat_last |=> burst_active_reg)
    else $error("burst stop ended a burst that is not full page");
  a_suspend_entry: assert property (power_reg == SCI_RUN && cke_prev_reg && !cke &&
    burst_active_reg |=> power_reg == SCI_SUSPEND)
    else $error("clock enable low during a burst did not suspend");
  a_burst_length: assert property (run && burst_active_reg && beat_last && !new_go
    |=> !burst_active_reg)
    else $error("burst ran past its programmed length");
  a_nop_keeps: assert property (sel && cmd == CMD_NOP && burst_active_reg && !beat_last
    |=> burst_active_reg)
    else $error("no-operation ended a burst");
  a_auto_close: assert property (ap_close |=> !open_vec[$past(beat_bank)])
    else $error("auto precharge left the bank open");
  a_refresh_count: assert property (ref_go && refresh_count_reg != REFRESH_MAX
    |=> refresh_count_reg == $past(refresh_count_reg) + 4'h1)
    else $error("refresh was not counted");

  c_read_burst: cover property (new_go && cmd == CMD_READ ##1 burst_active_reg [*3]);
  c_read_interrupt: cover property (rd_beat && burst_active_reg && new_go);
  c_suspend: cover property (power_reg == SCI_SUSPEND ##1 power_reg == SCI_RUN);
  c_self_refresh: cover property (power_reg == SCI_SELFREF);
endmodule // sci_sdram_device

// ---- tb/sci_ctl.sv ----
`timescale 1ns/1ps
module sci_ctl
  import sci_pkg::*;
#(
  parameter int PAUSE = 40000
) (
  input wire logic sys_clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic [ADDR_W-1:0] addr,
  output logic dqm,
  output logic [DATA_W-1:0] dq_in
);
  initial begin
    cke = 1'b1;
    dqm = 1'b1;
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = CMD_NOP;
    {bank_select_high, bank_select_low} = 2'h0;
    addr = 12'h000;
    dq_in = 4'h0;
  end
  // Strobes move only at the falling edge, so the device samples them settled.
  task issue(input logic [2:0] code, input logic [1:0] bank, input logic [ADDR_W-1:0] a);
    {ras_n, cas_n, we_n} = code;
    {bank_select_high, bank_select_low} = bank;
    addr = a;
    @(negedge sys_clk);
  endtask
  task idle(input int n);
    {ras_n, cas_n, we_n} = CMD_NOP;
    addr = ~addr;
    repeat (n) @(negedge sys_clk);
  endtask
  // A raised chip select must hide whatever code stands on the strobes.
  task deselect(input logic d);
    cs_n = d;
  endtask
  task pins(input logic c, input logic m);
    cke = c;
    dqm = m;
  endtask
  task init(input logic [ADDR_W-1:0] mode);
    idle(PAUSE);
    issue(CMD_PRECHARGE, 2'h1, 12'h400);
    repeat (8) issue(CMD_REFRESH, 2'h3, 12'h000);
    issue(CMD_MODE_LOAD, 2'h0, mode);
    idle(2);
    dqm = 1'b0;
  endtask
  // Two stray beats trail each burst; the device must drop them.
  task burst_write(input logic [3:0] col);
    dq_in = ~col;
    issue(CMD_WRITE, 2'h0, {8'h00, col});
    idle(0);
    for (int i = 1; i < 10; i++) begin
      dq_in = (i < 8) ? ~(col + 4'(i)) : 4'h0;
      @(negedge sys_clk);
    end
    dq_in = ~dq_in;
  endtask
endmodule // sci_ctl

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  import sci_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] mode;
    logic [3:0] col;
    logic [3:0] n;
    logic [31:0] cols;
  } sci_row_t;
  logic sys_clk, reset, cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, dqm;
  logic [ADDR_W-1:0] addr, mode_value;
  logic [DATA_W-1:0] dq_in, dq_out;
  logic dq_oe, wbuf_ready, mode_loaded, prior_cycle_clock_enable;
  logic [BANKS-1:0] bank_open;
  logic [3:0] refresh_count;
  sci_power_t power_state;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  sci_row_t rows [6] = '{'{12'h021, 4'h5, 4'h2, 32'h45}, '{12'h022, 4'h5, 4'h4, 32'h4765},
    '{12'h02A, 4'h5, 4'h4, 32'h6745}, '{12'h033, 4'hB, 4'h8, 32'hA98FEDCB},
    '{12'h03B, 4'hB, 4'h8, 32'hCDEF89AB}, '{12'h020, 4'h3, 4'h1, 32'h3}};

  sci_sdram_device i_sci_sdram_device (.sys_clk(sys_clk), .reset(reset), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_select_low(bank_select_low), .bank_select_high(bank_select_high), .addr(addr),
    .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .wbuf_ready(wbuf_ready),
    .bank_open(bank_open), .power_state(power_state), .mode_value(mode_value),
    .mode_loaded(mode_loaded), .refresh_count(refresh_count),
    .prior_cycle_clock_enable(prior_cycle_clock_enable));
  // The long power-up pause is shortened; the device does not time it.
  sci_ctl #(.PAUSE(50)) i_sci_ctl (.sys_clk(sys_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select_low(bank_select_low),
    .bank_select_high(bank_select_high), .addr(addr), .dqm(dqm), .dq_in(dq_in));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic setmode(input logic [ADDR_W-1:0] m);
    i_sci_ctl.issue(CMD_PRECHARGE, 2'h2, 12'h400);
    i_sci_ctl.issue(CMD_MODE_LOAD, 2'h0, m);
    i_sci_ctl.issue(CMD_ACTIVATE, 2'h0, 12'h000);
    i_sci_ctl.idle(2);
    chk(mode_value, m);
    chk(bank_open, 4'h1);
  endtask

  // A second command other than no-operation lands on the edge after the read.
  task automatic rd(input logic [9:0] col, input int cl, input int n, input logic [31:0] cols,
                    input logic [2:0] c2);
    i_sci_ctl.issue(CMD_READ, 2'h0, {2'h0, col});
    if (c2 != CMD_NOP) i_sci_ctl.issue(c2, 2'h0, 12'h000);
    i_sci_ctl.idle((c2 != CMD_NOP) ? cl - 2 : cl - 1);
    for (int i = 0; i < n; i++) begin
      chk({dq_oe, dq_out}, {1'b1, ~cols[4*i+:4]});
      i_sci_ctl.idle(1);
    end
    chk(dq_oe, 1'b0);
  endtask

  initial begin
    reset = 1'b1;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({bank_open, mode_value, mode_loaded, refresh_count, dq_oe, power_state,
         prior_cycle_clock_enable}, 32'h0);
    reset = 1'b0;
    i_sci_ctl.init(12'h023);
    chk({mode_loaded, mode_value}, {1'b1, 12'h023});
    chk(refresh_count, 4'h8);
    i_sci_ctl.issue(CMD_ACTIVATE, 2'h0, 12'h000);
    i_sci_ctl.idle(2);
    i_sci_ctl.burst_write(4'h8);
    i_sci_ctl.idle(1);
    i_sci_ctl.burst_write(4'h0);
    i_sci_ctl.idle(20);
    chk(wbuf_ready, 1'b1);
    i_sci_ctl.issue(CMD_REFRESH, 2'h0, 12'h000);
    i_sci_ctl.issue(CMD_MODE_LOAD, 2'h0, 12'h055);
    i_sci_ctl.idle(2);
    chk({refresh_count, mode_value}, {4'h8, 12'h023});
    $display("test init and fill done");
    foreach (rows[r]) begin
      setmode(rows[r].mode);
      rd({6'h0, rows[r].col}, rows[r].mode[6:4], rows[r].n, rows[r].cols, CMD_NOP);
    end
    $display("test burst orders done");
    // Full page is the only length in which a stop cuts the burst after one beat.
    setmode(12'h027);
    rd(10'h004, 2, 1, 32'h4, CMD_BURST_STOP);
    setmode(12'h022);
    rd(10'h004, 2, 4, 32'h7654, CMD_BURST_STOP);
    i_sci_ctl.issue(CMD_READ, 2'h0, 12'h000);
    i_sci_ctl.issue(CMD_READ, 2'h0, 12'h008);
    i_sci_ctl.idle(0);
    chk({dq_oe, dq_out}, {1'b1, 4'hF});
    for (int i = 0; i < 4; i++) begin
      i_sci_ctl.idle(1);
      chk({dq_oe, dq_out}, {1'b1, ~(4'h8 + 4'(i))});
    end
    i_sci_ctl.idle(1);
    i_sci_ctl.issue(CMD_READ, 2'h0, 12'h000);
    i_sci_ctl.pins(1'b1, 1'b1);
    i_sci_ctl.issue(CMD_WRITE, 2'h0, 12'h003);
    i_sci_ctl.idle(1);
    for (int i = 0; i < 3; i++) begin
      chk(dq_oe, 1'b0);
      i_sci_ctl.idle(1);
    end
    i_sci_ctl.pins(1'b1, 1'b0);
    rd(10'h003, 2, 4, 32'h2103, CMD_NOP);
    i_sci_ctl.issue(CMD_READ, 2'h0, 12'h400);
    i_sci_ctl.idle(8);
    chk(bank_open, 4'h0);
    $display("test interrupts done");
    i_sci_ctl.issue(CMD_ACTIVATE, 2'h3, 12'h000);
    i_sci_ctl.issue(CMD_READ, 2'h1, 12'h000);
    i_sci_ctl.issue(CMD_ACTIVATE, 2'h0, 12'h000);
    i_sci_ctl.idle(1);
    chk({dq_oe, bank_open}, {1'b0, 4'h9});
    i_sci_ctl.issue(CMD_PRECHARGE, 2'h3, 12'h000);
    i_sci_ctl.idle(1);
    chk(bank_open, 4'h1);
    i_sci_ctl.deselect(1'b1);
    i_sci_ctl.issue(CMD_ACTIVATE, 2'h2, 12'h000);
    i_sci_ctl.deselect(1'b0);
    i_sci_ctl.idle(1);
    chk(bank_open, 4'h1);
    i_sci_ctl.issue(CMD_PRECHARGE, 2'h0, 12'h400);
    i_sci_ctl.pins(1'b0, 1'b0);
    i_sci_ctl.idle(2);
    chk({power_state, bank_open, prior_cycle_clock_enable}, {SCI_PWRDN, 4'h0, 1'b0});
    i_sci_ctl.pins(1'b1, 1'b0);
    i_sci_ctl.issue(CMD_ACTIVATE, 2'h0, 12'h000);
    i_sci_ctl.idle(2);
    chk({power_state, bank_open, prior_cycle_clock_enable}, {SCI_RUN, 4'h0, 1'b1});
    i_sci_ctl.pins(1'b0, 1'b0);
    i_sci_ctl.issue(CMD_REFRESH, 2'h0, 12'h000);
    i_sci_ctl.idle(2);
    chk(power_state, SCI_SELFREF);
    i_sci_ctl.pins(1'b1, 1'b0);
    i_sci_ctl.idle(2);
    chk(power_state, SCI_RUN);
    setmode(12'h023);
    i_sci_ctl.issue(CMD_READ, 2'h0, 12'h000);
    i_sci_ctl.idle(2);
    i_sci_ctl.pins(1'b0, 1'b0);
    i_sci_ctl.idle(3);
    chk({power_state, dq_out}, {SCI_SUSPEND, 4'hD});
    i_sci_ctl.pins(1'b1, 1'b0);
    for (int k = 0; k < 4 && dq_out === 4'hD; k++) i_sci_ctl.idle(1);
    chk(dq_out, 4'hC);
    $display("test power modes done");
    reset = 1'b1;
    @(negedge sys_clk);
    chk({bank_open, mode_loaded, dq_oe}, 32'h0);
    reset = 1'b0;
    i_sci_ctl.idle(2);
    chk({power_state, prior_cycle_clock_enable}, {SCI_RUN, 1'b1});
    $display("test second reset done");
    give_verdict();
  end
endmodule // tb
